// file: logic/fppc_pkg.sv
// fppc_pkg: constants, carriers and state of the page program controller.
// assumes: one pclk domain, APB register access, flash array outside the block.
`default_nettype none
package fppc_pkg;
   // -------------------------------------------------------------------
   // register map and fields
   // -------------------------------------------------------------------
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_FLO  = 8'h04;
   localparam logic [7:0] OFF_FHI  = 8'h08;
   localparam logic [7:0] OFF_SIG0 = 8'h0C;
   localparam logic [7:0] OFF_SIG1 = 8'h10;
   localparam logic [7:0] OFF_SIG2 = 8'h14;
   localparam logic [7:0] OFF_OSC  = 8'h18;
   localparam logic [7:0] OFF_STAT = 8'h1C;
   localparam int         CB_CLR   = 4;
   localparam logic [7:0] CMD_LOAD  = 8'h01;
   localparam logic [7:0] CMD_ERASE = 8'h03;
   localparam logic [7:0] CMD_WRITE = 8'h05;
   localparam logic [2:0] STORE_WIN = 3'h4;
   localparam logic [15:0] ERASE_CYC = 16'h00C8;
   localparam logic [15:0] WRITE_CYC = 16'h00C8;
   localparam logic [7:0] FUSE_LO_RST = 8'h62;
   localparam logic [7:0] FUSE_HI_RST = 8'hFF;
   localparam int         FB_DIV8   = 7;
   localparam int         FB_CLKOUT = 6;
   localparam int         FB_EEKEEP = 3;
   localparam logic [1:0] ACT_ADDR = 2'h0;
   localparam logic [1:0] ACT_DATA = 2'h1;
   localparam logic [1:0] ACT_CMD  = 2'h2;
   localparam logic [7:0] CMD_NOP  = 8'h00;
   localparam int         WIDX_W = 6;
   localparam int         PAGE_W = 7;
   localparam int         NWORDS = 64;
   localparam logic [WIDX_W-1:0] LAST_W = 6'h3F;
   localparam logic [15:0] ERASED = 16'hFFFF;

   // -------------------------------------------------------------------
   // carriers and state
   // -------------------------------------------------------------------
   typedef enum logic [1:0] {ST_IDLE, ST_ERASE, ST_PROG, ST_WAIT} fppc_state_t;
   typedef struct packed {
      logic [1:0] act;
      logic       bs;
      logic [7:0] data;
      logic       load;
      logic       page_latch;
      logic       wr_n;
   } fppc_ppin_t;
   typedef struct packed {
      logic        we;
      logic        erase;
      logic [PAGE_W+WIDX_W-1:0] addr;
      logic [15:0] data;
   } fppc_flash_t;
   typedef struct packed {
      fppc_state_t st;
      logic [7:0]  cmd;
      logic [2:0]  win;
      logic [15:0] busy;
      logic [WIDX_W-1:0] wcnt;
      logic [PAGE_W-1:0] page;
      logic        src_cpu;
      logic [NWORDS-1:0][15:0] buf_d;
      logic [NWORDS-1:0] vld;
      logic [7:0]  fuse_lo;
      logic [7:0]  fuse_hi;
      logic [7:0]  lat_lo;
      logic        prog_q;
      logic        boot;
      logic [7:0]  osc;
      logic [7:0]  alo;
      logic [7:0]  ahi;
      logic [7:0]  dlo;
      logic [7:0]  dhi;
      logic        armed;
      logic        ld_q;
      logic        pl_q;
      logic        wr_q;
      logic [31:0] prdata;
      logic        slverr;
      fppc_flash_t fl;
   } fppc_state_s_t;
endpackage
`default_nettype wire

// file: logic/fppc_top.sv
// fppc_top: page buffer, self-program sequencer, parallel programmer port,
// fuse latching, identification bytes and oscillator trim.
// assumes: cpu gives a one-cycle store pulse with pointer and data pair;
// flash array accepts word writes and page erase pulses.
`default_nettype none
module fppc_top #(
   parameter logic [7:0] SIG0 = 8'h5A, // arbitrary value
   parameter logic [7:0] SIG1 = 8'hA5, // arbitrary value
   parameter logic [7:0] SIG2 = 8'h3C, // arbitrary value
   parameter logic [7:0] CAL  = 8'h80  // arbitrary value
) (
   input  wire logic               pclk,
   input  wire logic               presetn,
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [7:0]         paddr,
   input  wire logic [31:0]        pwdata,
   output logic                    pready,
   output logic [31:0]             prdata,
   output logic                    pslverr,
   input  wire logic               store_pulse,
   input  wire logic [15:0]        z_ptr,
   input  wire logic [15:0]        data_pair,
   input  wire logic               ee_write,
   output logic                    cpu_stall,
   input  wire logic               prog_mode,
   input  wire fppc_pkg::fppc_ppin_t ppin,
   output logic                    completion_pin,
   output fppc_pkg::fppc_flash_t   flash,
   output logic [7:0]              osc_trim,
   output logic                    clk_div8,
   output logic [1:0]              startup_time,
   output logic [3:0]              clock_source,
   output logic                    eeprom_preserve,
   output logic                    clkout_pin
);
   fppc_pkg::fppc_state_s_t s_r;
   fppc_pkg::fppc_state_s_t s_nxt;

   // -------------------------------------------------------------------
   // decoders
   // -------------------------------------------------------------------
   // byte pointer: bit 0 selects byte, next six bits the word, next seven the page, top two unused
   function automatic logic [fppc_pkg::WIDX_W-1:0] widx_of(input logic [15:0] z);
      widx_of = z[fppc_pkg::WIDX_W:1];
   endfunction
   function automatic logic [fppc_pkg::PAGE_W-1:0] page_of(input logic [15:0] z);
      page_of = z[fppc_pkg::WIDX_W+fppc_pkg::PAGE_W:fppc_pkg::WIDX_W+1];
   endfunction

   logic wr_acc;
   logic rd_setup;
   logic idle;
   assign wr_acc   = psel & penable & pwrite;
   assign rd_setup = psel & ~penable;
   assign idle     = (s_r.st == fppc_pkg::ST_IDLE);

   // -------------------------------------------------------------------
   // next state
   // -------------------------------------------------------------------
   always_comb
   begin
      logic [7:0] pw;
      pw = pwdata[7:0];
      s_nxt = s_r;
      s_nxt.fl.we = 1'b0;
      s_nxt.fl.erase = 1'b0;
      s_nxt.boot = 1'b0;
      s_nxt.prog_q = prog_mode;
      s_nxt.ld_q = ppin.load;
      s_nxt.pl_q = ppin.page_latch;
      s_nxt.wr_q = ppin.wr_n;

      // register reads are captured in the setup cycle so data comes from flops
      if (rd_setup)
      begin
         s_nxt.slverr = 1'b0;
         case (paddr)
            fppc_pkg::OFF_CTRL: s_nxt.prdata = {24'h0, s_r.cmd};
            fppc_pkg::OFF_FLO:  s_nxt.prdata = {24'h0, s_r.fuse_lo};
            fppc_pkg::OFF_FHI:  s_nxt.prdata = {24'h0, s_r.fuse_hi};
            fppc_pkg::OFF_SIG0: s_nxt.prdata = {16'h0, CAL, SIG0};
            fppc_pkg::OFF_SIG1: s_nxt.prdata = {24'h0, SIG1};
            fppc_pkg::OFF_SIG2: s_nxt.prdata = {24'h0, SIG2};
            fppc_pkg::OFF_OSC:  s_nxt.prdata = {24'h0, s_r.osc};
            fppc_pkg::OFF_STAT: s_nxt.prdata = {22'h0, s_r.lat_lo, ~idle, s_r.armed};
            default:
            begin
               s_nxt.prdata = 32'h0;
               s_nxt.slverr = 1'b1;
            end
         endcase
      end

      // register writes; fuses only change in programming mode
      if (wr_acc)
      begin
         case (paddr)
            fppc_pkg::OFF_CTRL:
            begin
               if (idle)
               begin
                  s_nxt.cmd = pw & ~(8'h01 << fppc_pkg::CB_CLR);
                  s_nxt.win = fppc_pkg::STORE_WIN;
                  if (pw[fppc_pkg::CB_CLR])
                     s_nxt.vld = '0;
               end
            end
            fppc_pkg::OFF_FLO: if (prog_mode) s_nxt.fuse_lo = pw;
            fppc_pkg::OFF_FHI: if (prog_mode) s_nxt.fuse_hi = pw;
            fppc_pkg::OFF_OSC: s_nxt.osc = pw;
            default: ;
         endcase
      end

      // window count; a late store pulse finds the command gone
      if (s_r.win != 3'h0 && !(wr_acc && paddr == fppc_pkg::OFF_CTRL))
      begin
         s_nxt.win = s_r.win - 3'h1;
         if (s_r.win == 3'h1)
            s_nxt.cmd = 8'h00;
      end

      // self-programming commands
      if (store_pulse && s_r.win != 3'h0 && idle)
      begin
         s_nxt.win = 3'h0;
         s_nxt.cmd = 8'h00;
         case (s_r.cmd)
            fppc_pkg::CMD_LOAD:
            begin
               s_nxt.buf_d[widx_of(z_ptr)] = data_pair;
               s_nxt.vld[widx_of(z_ptr)] = 1'b1;
            end
            fppc_pkg::CMD_ERASE:
            begin
               s_nxt.page = page_of(z_ptr);
               s_nxt.st = fppc_pkg::ST_ERASE;
               s_nxt.busy = fppc_pkg::ERASE_CYC;
               s_nxt.src_cpu = 1'b1;
               s_nxt.fl.erase = 1'b1;
               s_nxt.fl.addr = {page_of(z_ptr), {fppc_pkg::WIDX_W{1'b0}}};
            end
            fppc_pkg::CMD_WRITE:
            begin
               s_nxt.page = page_of(z_ptr);
               s_nxt.st = fppc_pkg::ST_PROG;
               s_nxt.wcnt = '0;
               s_nxt.src_cpu = 1'b1;
            end
            default: ;
         endcase
      end
      else if (store_pulse && idle)
         s_nxt.cmd = 8'h00;

      // an eeprom write mid-load throws away what was loaded
      if (ee_write && idle)
         s_nxt.vld = '0;

      // parallel programmer strobes, edge detected on synchronous pins
      if (prog_mode && idle)
      begin
         if (ppin.load && !s_r.ld_q)
         begin
            case (ppin.act)
               fppc_pkg::ACT_ADDR:
                  if (ppin.bs) s_nxt.ahi = ppin.data;
                  else s_nxt.alo = ppin.data;
               fppc_pkg::ACT_DATA:
                  if (ppin.bs) s_nxt.dhi = ppin.data;
                  else s_nxt.dlo = ppin.data;
               fppc_pkg::ACT_CMD:
                  s_nxt.armed = (ppin.data != fppc_pkg::CMD_NOP);
               default: ;
            endcase
         end
         if (ppin.page_latch && !s_r.pl_q && ppin.bs)
         begin
            s_nxt.buf_d[s_r.alo[fppc_pkg::WIDX_W-1:0]] = {s_r.dhi, s_r.dlo};
            s_nxt.vld[s_r.alo[fppc_pkg::WIDX_W-1:0]] = 1'b1;
         end
         if (!ppin.wr_n && s_r.wr_q && s_r.armed)
         begin
            // spare low-byte bits join the page number
            s_nxt.page = {s_r.ahi[fppc_pkg::PAGE_W-3:0], s_r.alo[7:6]};
            s_nxt.st = fppc_pkg::ST_PROG;
            s_nxt.wcnt = '0;
            s_nxt.src_cpu = 1'b0;
         end
      end

      // sequencer: stream the page out word by word, then wait for the array
      case (s_r.st)
         fppc_pkg::ST_IDLE: ;
         fppc_pkg::ST_PROG:
         begin
            s_nxt.fl.we = 1'b1;
            s_nxt.fl.addr = {s_r.page, s_r.wcnt};
            s_nxt.fl.data = s_r.vld[s_r.wcnt] ? s_r.buf_d[s_r.wcnt] : fppc_pkg::ERASED;
            s_nxt.wcnt = s_r.wcnt + 1'b1;
            if (s_r.wcnt == fppc_pkg::LAST_W)
            begin
               s_nxt.st = fppc_pkg::ST_WAIT;
               s_nxt.busy = fppc_pkg::WRITE_CYC;
               s_nxt.vld = '0;
            end
         end
         fppc_pkg::ST_ERASE, fppc_pkg::ST_WAIT:
         begin
            s_nxt.busy = s_r.busy - 16'h1;
            if (s_r.busy == 16'h1)
               s_nxt.st = fppc_pkg::ST_IDLE;
         end
         default: s_nxt.st = fppc_pkg::ST_IDLE;
      endcase

      // fuse capture at power-up and on entry; exit applies changes made inside
      if (s_r.boot || (prog_mode != s_r.prog_q))
         s_nxt.lat_lo = s_r.fuse_lo;
   end

   // -------------------------------------------------------------------
   // state register
   // -------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s_r <= '0;
         s_r.st <= fppc_pkg::ST_IDLE;
         s_r.fuse_lo <= fppc_pkg::FUSE_LO_RST;
         s_r.fuse_hi <= fppc_pkg::FUSE_HI_RST;
         s_r.lat_lo <= fppc_pkg::FUSE_LO_RST;
         s_r.boot <= 1'b1;
         s_r.osc <= CAL;
         s_r.ld_q <= 1'b0;
         s_r.wr_q <= 1'b1;
      end
      else
         s_r <= s_nxt;
   end

   // -------------------------------------------------------------------
   // outputs
   // -------------------------------------------------------------------
   // zero wait state; data was captured in the setup cycle
   assign pready = 1'b1;
   assign prdata = s_r.prdata;
   assign pslverr = s_r.slverr & psel & penable;
   assign cpu_stall = s_r.src_cpu & ~idle;
   assign completion_pin = idle;
   assign flash = s_r.fl;
   assign osc_trim = s_r.osc;
   // programmed fuse bits read as zero
   assign clk_div8 = ~s_r.lat_lo[fppc_pkg::FB_DIV8];
   assign startup_time = s_r.lat_lo[5:4];
   assign clock_source = s_r.lat_lo[3:0];
   // live store bit, not the latched copy, so it acts at once
   assign eeprom_preserve = ~s_r.fuse_hi[fppc_pkg::FB_EEKEEP];
   // glitch risk only when the fuse latch changes, which is rare
   assign clkout_pin = pclk & ~s_r.lat_lo[fppc_pkg::FB_CLKOUT];

   // -------------------------------------------------------------------
   // checks
   // -------------------------------------------------------------------
   // busy span in cycles, zeroed whenever the sequencer is idle
   logic [15:0] stall_cnt;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         stall_cnt <= 16'h0;
      else if (idle)
         stall_cnt <= 16'h0;
      else
         stall_cnt <= stall_cnt + 16'h1;
   end

   // cycles spent streaming one page; a 64-deep repeat would unroll in the tools
   logic [6:0] prog_cnt;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prog_cnt <= 7'h00;
      else if (s_r.st == fppc_pkg::ST_PROG)
         prog_cnt <= prog_cnt + 7'h01;
      else if (idle)
         prog_cnt <= 7'h00;
   end

   // stall and timing of the array operations
   stall_erase_a: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(s_r.st == fppc_pkg::ST_ERASE) && s_r.src_cpu |-> cpu_stall [*8])
      else $error("cpu not stalled during erase");
   stall_write_a: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(s_r.st == fppc_pkg::ST_PROG) && s_r.src_cpu |-> cpu_stall [*8])
      else $error("cpu not stalled during page write");
   erase_len_a: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(s_r.st == fppc_pkg::ST_ERASE) |-> ##200 idle)
      else $error("erase length wrong");
   prog_len_a: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(s_r.st == fppc_pkg::ST_WAIT) |-> prog_cnt == 7'(fppc_pkg::NWORDS))
      else $error("page stream length wrong");
   we_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
      flash.we == $past(s_r.st == fppc_pkg::ST_PROG))
      else $error("word write strobe out of step");
   stall_pin_a: assert property (@(posedge pclk) disable iff (!presetn)
      !completion_pin |-> stall_cnt < 16'h0108)
      else $error("completion pin low too long");

   // buffer clearing and the store window
   buf_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(s_r.st == fppc_pkg::ST_WAIT) |-> s_r.vld == '0)
      else $error("buffer not cleared after write");
   clr_bit_a: assert property (@(posedge pclk) disable iff (!presetn)
      wr_acc && paddr == fppc_pkg::OFF_CTRL && idle && pwdata[fppc_pkg::CB_CLR]
      && !store_pulse && !prog_mode |=> s_r.vld == '0)
      else $error("clear bit kept buffer");
   win_close_a: assert property (@(posedge pclk) disable iff (!presetn)
      wr_acc && paddr == fppc_pkg::OFF_CTRL && idle && !pwdata[fppc_pkg::CB_CLR]
      ##1 (!store_pulse && !wr_acc) [*4] |=> s_r.cmd == 8'h00)
      else $error("command survived window");
   ee_drop_a: assert property (@(posedge pclk) disable iff (!presetn)
      ee_write && idle |=> s_r.vld == '0)
      else $error("eeprom write kept buffer");

   // fuse latch and identification reads
   latch_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
      prog_mode && $past(prog_mode) && s_r.prog_q && !s_r.boot |=> $stable(s_r.lat_lo))
      else $error("fuse latch moved inside programming mode");
   sig_read_a: assert property (@(posedge pclk) disable iff (!presetn)
      rd_setup && paddr == fppc_pkg::OFF_SIG1 |=> prdata == {24'h0, SIG1})
      else $error("id byte read wrong");

   // covers for the main scenarios
   erase_c: cover property (@(posedge pclk) disable iff (!presetn)
      $rose(s_r.st == fppc_pkg::ST_ERASE));
   load_c: cover property (@(posedge pclk) disable iff (!presetn)
      store_pulse && s_r.win != 3'h0 && s_r.cmd == fppc_pkg::CMD_LOAD);
   cpu_wr_c: cover property (@(posedge pclk) disable iff (!presetn)
      $rose(s_r.st == fppc_pkg::ST_PROG) && s_r.src_cpu);
   par_wr_c: cover property (@(posedge pclk) disable iff (!presetn)
      $rose(s_r.st == fppc_pkg::ST_PROG) && !s_r.src_cpu);
   ee_c: cover property (@(posedge pclk) disable iff (!presetn)
      ee_write && idle && s_r.vld != '0);
endmodule
`default_nettype wire

// file: bench/fppc_prog_model.sv
// fppc_prog_model: behavioural parallel programmer driving the page program port.
// assumes: its tasks are called from a process that follows pclk.
`default_nettype none
module fppc_prog_model (
   input  wire logic                pclk,
   output var  fppc_pkg::fppc_ppin_t ppin
);
   timeunit 1ns;
   timeprecision 1ns;

   // -------------------------------------------------------------------
   // idle lines and strobe tasks
   // -------------------------------------------------------------------
   // strobes low and write strobe high, so nothing is started at reset
   initial
   begin
      ppin = '0;
      ppin.wr_n = 1'b1;
   end

   // one byte with a positive load strobe; lines held around the strobe
   task automatic strobe(input logic [1:0] act, input logic bs, input logic [7:0] d);
      @(posedge pclk);
      ppin.act  <= act;
      ppin.bs   <= bs;
      ppin.data <= d;
      @(posedge pclk);
      ppin.load <= 1'b1;
      @(posedge pclk);
      ppin.load <= 1'b0;
      @(posedge pclk);
      ppin.data <= ~d; // released bus must not keep the old byte
   endtask

   // page latch strobe, byte select held high around it
   task automatic latch();
      @(posedge pclk);
      ppin.bs <= 1'b1;
      @(posedge pclk);
      ppin.page_latch <= 1'b1;
      @(posedge pclk);
      ppin.page_latch <= 1'b0;
   endtask

   // one-cycle negative pulse on the write strobe
   task automatic pulse_wr();
      @(posedge pclk);
      ppin.wr_n <= 1'b0;
      @(posedge pclk);
      ppin.wr_n <= 1'b1;
   endtask
endmodule
`default_nettype wire

// file: bench/tb.sv
// tb: self-checking bench for the page program controller.
// assumes: design has zero-wait APB; tb plays cpu and flash array.
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [7:0] CAL = 8'h96; // arbitrary value
   localparam logic [7:0] SG0 = 8'h11; // arbitrary value
   localparam logic [7:0] SG1 = 8'h22; // arbitrary value
   localparam logic [7:0] SG2 = 8'h33; // arbitrary value
   logic                 pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
   logic                 store_pulse, ee_write, cpu_stall, prog_mode, completion_pin;
   logic                 clk_div8, eeprom_preserve, clkout_pin;
   logic [7:0]           paddr, osc_trim;
   logic [31:0]          pwdata, prdata, rdat;
   logic [15:0]          z_ptr, data_pair;
   logic [1:0]           startup_time;
   logic [3:0]           clock_source;
   fppc_pkg::fppc_ppin_t ppin;
   fppc_pkg::fppc_flash_t flash;
   logic [15:0]          mem [0:8191];
   int                   n_erase, n_fail, checks_done;

   fppc_top #(.SIG0(SG0), .SIG1(SG1), .SIG2(SG2), .CAL(CAL)) fppc_top_i (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .store_pulse(store_pulse), .z_ptr(z_ptr), .data_pair(data_pair), .ee_write(ee_write),
      .cpu_stall(cpu_stall), .prog_mode(prog_mode), .ppin(ppin),
      .completion_pin(completion_pin), .flash(flash), .osc_trim(osc_trim),
      .clk_div8(clk_div8), .startup_time(startup_time), .clock_source(clock_source),
      .eeprom_preserve(eeprom_preserve), .clkout_pin(clkout_pin));
   fppc_prog_model fppc_prog_model_i (.pclk(pclk), .ppin(ppin));

   // -------------------------------------------------------------------
   // clock, flash array stand-in, helpers
   // -------------------------------------------------------------------
   initial
   begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   // flash array: keeps programmed words and counts erase pulses
   always @(posedge pclk)
   begin
      if (flash.we === 1'b1)
         mem[flash.addr] <= flash.data;
      if (flash.erase === 1'b1)
         n_erase <= n_erase + 1;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // apb transfer; read data and error taken at the pready edge only
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   function automatic logic [15:0] zp(input int page, input int word);
      return 16'((page << 7) | (word << 1));
   endfunction

   // control write, then the store pulse in the first cycle of the window
   task automatic cmd(input logic [7:0] c, input logic [15:0] z, input logic [15:0] d);
      apb(1'b1, fppc_pkg::OFF_CTRL, 32'(c));
      store_pulse <= 1'b1;
      z_ptr       <= z;
      data_pair   <= d;
      @(posedge pclk);
      store_pulse <= 1'b0;
   endtask

   // bounded wait: a hung sequencer is a failure, not a stuck run
   task automatic wait_idle();
      int n;
      n = 0;
      // one edge first, so a command taken at the last edge already shows busy
      @(posedge pclk);
      while ((cpu_stall !== 1'b0 || completion_pin !== 1'b1) && n < 600)
      begin
         @(posedge pclk);
         n++;
      end
      chk(32'(n < 600), 32'h1);
   endtask

   task automatic summarize();
      $display("checks %0d failures %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   initial
   begin
      repeat (10000) @(posedge pclk);
      n_fail++;
      summarize();
   end

   // -------------------------------------------------------------------
   // test sequence
   // -------------------------------------------------------------------
   initial
   begin
      {presetn, psel, penable, pwrite, store_pulse, ee_write, prog_mode} = '0;
      {paddr, pwdata, z_ptr, data_pair} = '0;
      {n_erase, n_fail, checks_done} = '0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      chk(32'(osc_trim), 32'(CAL));
      chk(32'({clk_div8, startup_time, clock_source}), 32'h62);
      apb(1'b0, fppc_pkg::OFF_SIG0, '0);
      chk(32'(rdat[15:0]), 32'({CAL, SG0}));
      apb(1'b0, fppc_pkg::OFF_SIG1, '0);
      chk(32'(rdat[7:0]), 32'(SG1));
      chk(32'(rerr), 32'h0);
      apb(1'b0, fppc_pkg::OFF_SIG2, '0);
      chk(32'(rdat[7:0]), 32'(SG2));
      apb(1'b0, 8'h40, '0);
      chk(32'(rerr), 32'h1);
      // erase page 5, then load two words and program the same page
      cmd(fppc_pkg::CMD_ERASE, zp(5, 0), 16'h0);
      repeat (2) @(posedge pclk);
      chk(32'(cpu_stall), 32'h1);
      wait_idle();
      chk(32'(n_erase), 32'h1);
      cmd(fppc_pkg::CMD_LOAD, zp(0, 3), 16'hBEEF);
      cmd(fppc_pkg::CMD_LOAD, zp(0, 63), 16'h1234);
      cmd(fppc_pkg::CMD_WRITE, zp(5, 0), 16'h0);
      repeat (2) @(posedge pclk);
      chk(32'(cpu_stall), 32'h1);
      wait_idle();
      chk(32'(mem[323]), 32'hBEEF);
      chk(32'(mem[383]), 32'h1234);
      chk(32'(mem[320]), 32'hFFFF);
      // buffer emptied by the write, by the clear bit and by an eeprom write
      cmd(fppc_pkg::CMD_WRITE, zp(6, 0), 16'h0);
      wait_idle();
      chk(32'(mem[387]), 32'hFFFF);
      cmd(fppc_pkg::CMD_LOAD, zp(0, 1), 16'h1111);
      apb(1'b1, fppc_pkg::OFF_CTRL, 32'h10);
      cmd(fppc_pkg::CMD_LOAD, zp(0, 2), 16'h2222);
      ee_write <= 1'b1;
      @(posedge pclk);
      ee_write <= 1'b0;
      cmd(fppc_pkg::CMD_WRITE, zp(7, 0), 16'h0);
      wait_idle();
      chk(32'(mem[449]), 32'hFFFF);
      chk(32'(mem[450]), 32'hFFFF);
      // store pulse after the four-cycle window is ignored
      apb(1'b1, fppc_pkg::OFF_CTRL, 32'(fppc_pkg::CMD_ERASE));
      repeat (6) @(posedge pclk);
      store_pulse <= 1'b1;
      @(posedge pclk);
      store_pulse <= 1'b0;
      repeat (3) @(posedge pclk);
      chk(32'(cpu_stall), 32'h0);
      chk(32'(n_erase), 32'h1);
      // trim write, then a mid-run reset empties the buffer and reloads the trim
      apb(1'b1, fppc_pkg::OFF_OSC, 32'h3C);
      @(posedge pclk);
      chk(32'(osc_trim), 32'h3C);
      cmd(fppc_pkg::CMD_LOAD, zp(0, 4), 16'h4444);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk(32'(osc_trim), 32'(CAL));
      cmd(fppc_pkg::CMD_WRITE, zp(8, 0), 16'h0);
      wait_idle();
      chk(32'(mem[516]), 32'hFFFF);
      // fuse store refuses writes outside programming mode
      apb(1'b1, fppc_pkg::OFF_FLO, 32'h00);
      apb(1'b0, fppc_pkg::OFF_FLO, '0);
      chk(32'(rdat[7:0]), 32'(fppc_pkg::FUSE_LO_RST));
      // parallel program: word 2 of page 7 from address bytes 0x01/0xC2
      prog_mode <= 1'b1;
      fppc_prog_model_i.strobe(fppc_pkg::ACT_CMD, 1'b0, 8'h10);
      fppc_prog_model_i.strobe(fppc_pkg::ACT_ADDR, 1'b0, 8'hC2);
      fppc_prog_model_i.strobe(fppc_pkg::ACT_DATA, 1'b0, 8'h5A);
      fppc_prog_model_i.strobe(fppc_pkg::ACT_DATA, 1'b1, 8'hC3);
      fppc_prog_model_i.latch();
      fppc_prog_model_i.strobe(fppc_pkg::ACT_ADDR, 1'b1, 8'h01);
      fppc_prog_model_i.pulse_wr();
      repeat (2) @(posedge pclk);
      chk(32'(completion_pin), 32'h0);
      chk(32'(cpu_stall), 32'h0);
      wait_idle();
      chk(32'(mem[450]), 32'hC35A);
      fppc_prog_model_i.strobe(fppc_pkg::ACT_CMD, 1'b0, fppc_pkg::CMD_NOP);
      fppc_prog_model_i.pulse_wr();
      repeat (2) @(posedge pclk);
      chk(32'(completion_pin), 32'h1);
      // fuse changes: preserve acts at once, the rest on leaving the mode
      apb(1'b1, fppc_pkg::OFF_FLO, 32'h23);
      apb(1'b1, fppc_pkg::OFF_FHI, 32'hF7);
      @(posedge pclk);
      chk(32'(eeprom_preserve), 32'h1);
      chk(32'(clock_source), 32'h2);
      prog_mode <= 1'b0;
      repeat (3) @(posedge pclk);
      chk(32'({clk_div8, startup_time, clock_source}), 32'h63);
      #2;
      chk(32'(clkout_pin), 32'h1);
      #5;
      chk(32'(clkout_pin), 32'h0);
      summarize();
   end
endmodule
`default_nettype wire
